// ---- ars_defs.svh ----
// Purpose: Named constants for the alarm status readout block.
// Assumes: Included by the package and the top module by bare name.
// Notes:   Definitions only; no logic.
`ifndef ARS_DEFS_SVH
`define ARS_DEFS_SVH

// ============================================================
// Register map
`define ARS_ADDR_W        7
`define ARS_ADDR_VIEW     7'h43
`define ARS_ADDR_CLR      7'h44
`define ARS_REG_W         16
`define ARS_STATUS_RST    16'h0000

// ============================================================
// Serial frame layout, MSB first
`define ARS_FRAME_BITS    24
`define ARS_FRAME_LAST    5'h17
`define ARS_CNT_W         5
`define ARS_CNT_ZERO      5'h00
`define ARS_CNT_ONE       5'h01
`define ARS_RW_BIT        23
`define ARS_ADDR_MSB      22
`define ARS_ADDR_LSB      16
`define ARS_FRAME_RST     24'h000000

// ============================================================
// Status word bit positions
`define ARS_B_STK_TEMP    15
`define ARS_B_LIVE_TEMP   14
`define ARS_B_STK_OPEN    13
`define ARS_B_LIVE_OPEN   12
`define ARS_B_STK_GND     11
`define ARS_B_LIVE_GND    10
`define ARS_B_STK_CLAMP   9
`define ARS_B_LIVE_CLAMP  8
`define ARS_B_STK_GUARD   7
`define ARS_B_LIVE_GUARD  6
`define ARS_B_CMP_LOW     5
`define ARS_B_CMP_HIGH    4
`define ARS_UNUSED_MSB    3
`define ARS_UNUSED_LSB    0
`define ARS_UNUSED_VAL    4'h0

// ============================================================
// Alarm pins and idle values
`define ARS_PIN_N         3
`define ARS_PIN_TEMP      0
`define ARS_PIN_CLAMP     1
`define ARS_PIN_KELVIN    2
`define ARS_PIN_REL       3'h7
`define ARS_PIN_LOW       3'h0
`define ARS_ALARM_IDLE    5'h1f

`endif

// ---- ars_pkg.sv ----
// Purpose: Types shared by the alarm status readout block.
// Assumes: ars_defs.svh supplies every width.
// Notes:   Alarm structs are active low, one bit per alarm source.
package ars_pkg;
  `include "ars_defs.svh"

  // ============================================================
  // Alarm sources, low means alarm
  typedef struct packed {
    logic temp;
    logic open_sense;
    logic gnd_kelvin;
    logic clamp;
    logic guard;
  } ars_alarm_t;

  // ============================================================
  // Live inputs as they arrive from the analog side
  typedef struct packed {
    ars_alarm_t alarm;
    logic       cmp_low;
    logic       cmp_high;
  } ars_live_t;

  // ============================================================
  // Main domain state
  typedef struct packed {
    ars_alarm_t                  sticky_n;
    ars_alarm_t                  live_n;
    logic                        comparator_low_result;
    logic                        comparator_high_result;
    logic [`ARS_REG_W-1:0]       rb_word;
    logic                        cmd_seen;
    logic [`ARS_PIN_N-1:0]       pin_oe_n;
    logic [`ARS_PIN_N-1:0]       pin_val;
  } ars_main_st_t;

  // ============================================================
  // Link domain state
  typedef struct packed {
    logic [`ARS_CNT_W-1:0]       bit_cnt;
    logic [`ARS_FRAME_BITS-1:0]  shift_in;
    logic [`ARS_FRAME_BITS-1:0]  cmd_word;
    logic                        cmd_tgl;
    logic [`ARS_REG_W-1:0]       shift_out;
    logic                        sdo;
  } ars_link_st_t;
endpackage

// ---- ars_sync.sv ----
// Purpose: Two-stage synchroniser for levels and toggles.
// Assumes: d_in is static long enough to be seen at the clk_in rate.
// Notes:   The first stage feeds only the second stage.
module ars_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  input  wire logic [WIDTH-1:0] rst_val_in,
  output logic      [WIDTH-1:0] q_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ars_sync_st_t;

  ars_sync_st_t s_r;
  ars_sync_st_t s_nxt;

  // ============================================================
  // Next state
  always_comb begin
    s_nxt        = s_r;
    s_nxt.meta   = d_in;
    s_nxt.stable = s_r.meta;
  end

  // ============================================================
  // Registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= {rst_val_in, rst_val_in};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_out = s_r.stable;
endmodule

// ---- ars_top.sv ----
// Purpose: Alarm status readout registers behind the serial port.
// Assumes: mclk_in at 250 MHz; sclk_in is the host serial clock and
//          only runs inside frames framed by sync_n_in, apart from reset pulses.
// Notes:   Two domains; commands cross by toggle, readback by a
//          word held stable during frames.
`include "ars_defs.svh"

module ars_top (
  input  wire logic                   mclk_in,
  input  wire logic                   rst_in,
  input  wire logic                   sclk_in,
  input  wire logic                   sync_n_in,
  input  wire logic                   sdi_in,
  output logic                        sdo_out,
  input  wire ars_pkg::ars_alarm_t    alarm_live_n_in,
  input  wire logic                   cmp_low_in,
  input  wire logic                   cmp_high_in,
  output logic [`ARS_PIN_N-1:0]       alarm_pin_out,
  output logic [`ARS_PIN_N-1:0]       alarm_pin_oe_n_out
);
  localparam int LIVE_W = $bits(ars_pkg::ars_live_t);

  // ============================================================
  // Decoding shared by both read-only addresses
  function automatic logic ars_is_read(
    input logic [`ARS_FRAME_BITS-1:0] word,
    input logic [`ARS_ADDR_W-1:0]     addr
  );
    logic rw;
    logic hit;
    rw  = word[`ARS_RW_BIT];
    hit = (word[`ARS_ADDR_MSB:`ARS_ADDR_LSB] == addr);
    return rw && hit;
  endfunction

  // ============================================================
  // Status word assembly
  function automatic logic [`ARS_REG_W-1:0] ars_status_word(
    input ars_pkg::ars_main_st_t st
  );
    logic [`ARS_REG_W-1:0] w;
    w                   = `ARS_STATUS_RST;
    w[`ARS_B_STK_TEMP]   = st.sticky_n.temp;
    w[`ARS_B_LIVE_TEMP]  = st.live_n.temp;
    w[`ARS_B_STK_OPEN]   = st.sticky_n.open_sense;
    w[`ARS_B_LIVE_OPEN]  = st.live_n.open_sense;
    w[`ARS_B_STK_GND]    = st.sticky_n.gnd_kelvin;
    w[`ARS_B_LIVE_GND]   = st.live_n.gnd_kelvin;
    w[`ARS_B_STK_CLAMP]  = st.sticky_n.clamp;
    w[`ARS_B_LIVE_CLAMP] = st.live_n.clamp;
    w[`ARS_B_STK_GUARD]  = st.sticky_n.guard;
    w[`ARS_B_LIVE_GUARD] = st.live_n.guard;
    w[`ARS_B_CMP_LOW]    = st.comparator_low_result;
    w[`ARS_B_CMP_HIGH]   = st.comparator_high_result;
    w[`ARS_UNUSED_MSB:`ARS_UNUSED_LSB] = `ARS_UNUSED_VAL;
    return w;
  endfunction

  localparam ars_pkg::ars_main_st_t MAIN_RST = '{
    sticky_n:               ars_pkg::ars_alarm_t'(`ARS_ALARM_IDLE),
    live_n:                 ars_pkg::ars_alarm_t'(`ARS_ALARM_IDLE),
    comparator_low_result:  1'b0,
    comparator_high_result: 1'b0,
    rb_word:                `ARS_STATUS_RST,
    cmd_seen:               1'b0,
    pin_oe_n:               `ARS_PIN_REL,
    pin_val:                `ARS_PIN_LOW
  };

  localparam ars_pkg::ars_link_st_t LINK_RST = '{
    bit_cnt:   `ARS_CNT_ZERO,
    shift_in:  `ARS_FRAME_RST,
    cmd_word:  `ARS_FRAME_RST,
    cmd_tgl:   1'b0,
    shift_out: `ARS_STATUS_RST,
    sdo:       1'b0
  };

  ars_pkg::ars_main_st_t m_r;
  ars_pkg::ars_main_st_t m_nxt;
  ars_pkg::ars_link_st_t l_r;
  ars_pkg::ars_link_st_t l_nxt;
  ars_pkg::ars_live_t    live_raw;
  ars_pkg::ars_live_t    live_sync;
  logic [LIVE_W-1:0]     live_sync_bits;
  logic                  cmd_tgl_sync;
  logic                  link_rst;
  logic                  new_cmd;
  logic                  rd_view;
  logic                  rd_clr;
  logic                  clr_mask;

  // ============================================================
  // Crossings
  // Analog alarm and comparator levels are asynchronous to mclk_in
  assign live_raw.alarm    = alarm_live_n_in;
  assign live_raw.cmp_low  = cmp_low_in;
  assign live_raw.cmp_high = cmp_high_in;

  ars_sync #(
    .WIDTH (LIVE_W)
  ) u_live_sync (
    .clk_in     (mclk_in),
    .rst_in     (rst_in),
    .d_in       (live_raw),
    .rst_val_in ({`ARS_ALARM_IDLE, 1'b0, 1'b0}),
    .q_out      (live_sync_bits)
  );

  assign live_sync = ars_pkg::ars_live_t'(live_sync_bits);

  // Command toggle from the link side into the main clock
  ars_sync #(
    .WIDTH (1)
  ) u_cmd_sync (
    .clk_in     (mclk_in),
    .rst_in     (rst_in),
    .d_in       (l_r.cmd_tgl),
    .rst_val_in (1'b0),
    .q_out      (cmd_tgl_sync)
  );

  // Reset reaches the link side only while sclk_in runs
  ars_sync #(
    .WIDTH (1)
  ) u_rst_sync (
    .clk_in     (sclk_in),
    .rst_in     (1'b0),
    .d_in       (rst_in),
    .rst_val_in (1'b1),
    .q_out      (link_rst)
  );

  // ============================================================
  // Main domain: sticky flags, pins, readback capture
  always_comb begin
    m_nxt    = m_r;
    new_cmd  = (cmd_tgl_sync != m_r.cmd_seen);
    // cmd_word is held by the link side until the next frame ends
    rd_view  = new_cmd && ars_is_read(l_r.cmd_word, `ARS_ADDR_VIEW);
    rd_clr   = new_cmd && ars_is_read(l_r.cmd_word, `ARS_ADDR_CLR);
    clr_mask = rd_clr;

    if (new_cmd) begin
      m_nxt.cmd_seen = cmd_tgl_sync;
    end

    m_nxt.live_n                 = live_sync.alarm;
    m_nxt.comparator_low_result  = live_sync.cmp_low;
    m_nxt.comparator_high_result = live_sync.cmp_high;

    // Snapshot is taken before the clear so the read still shows it
    if (rd_view || rd_clr) begin
      m_nxt.rb_word = ars_status_word(m_r);
    end

    // A fresh alarm in the clearing cycle wins over the clear
    m_nxt.sticky_n = (m_r.sticky_n | {$bits(m_r.sticky_n){clr_mask}})
                     & m_r.live_n;

    m_nxt.pin_val = `ARS_PIN_LOW;
    m_nxt.pin_oe_n[`ARS_PIN_TEMP]   = m_nxt.sticky_n.temp;
    m_nxt.pin_oe_n[`ARS_PIN_CLAMP]  = m_nxt.sticky_n.clamp;
    m_nxt.pin_oe_n[`ARS_PIN_KELVIN] = m_nxt.sticky_n.open_sense
                                      & m_nxt.sticky_n.gnd_kelvin;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      m_r <= MAIN_RST;
    end else begin
      m_r <= m_nxt;
    end
  end

  // ============================================================
  // Link domain: frame shifter and readback driver
  // A frame cut short leaves the counter misaligned until reset;
  // the host must always send whole frames.
  always_comb begin
    l_nxt = l_r;
    if (!sync_n_in) begin
      l_nxt.shift_in = {l_r.shift_in[`ARS_FRAME_BITS-2:0], sdi_in};
      l_nxt.bit_cnt  = l_r.bit_cnt + `ARS_CNT_ONE;
      if (l_r.bit_cnt == `ARS_CNT_ZERO) begin
        // rb_word is updated just after a read frame ends and is stable by the next frame
        l_nxt.sdo       = m_r.rb_word[`ARS_REG_W-1];
        l_nxt.shift_out = {m_r.rb_word[`ARS_REG_W-2:0], 1'b0};
      end else begin
        l_nxt.sdo       = l_r.shift_out[`ARS_REG_W-1];
        l_nxt.shift_out = {l_r.shift_out[`ARS_REG_W-2:0], 1'b0};
      end
      if (l_r.bit_cnt == `ARS_FRAME_LAST) begin
        l_nxt.bit_cnt  = `ARS_CNT_ZERO;
        l_nxt.cmd_word = {l_r.shift_in[`ARS_FRAME_BITS-2:0], sdi_in};
        l_nxt.cmd_tgl  = !l_r.cmd_tgl;
      end
    end
  end

  always_ff @(posedge sclk_in) begin
    if (link_rst) begin
      l_r <= LINK_RST;
    end else begin
      l_r <= l_nxt;
    end
  end

  // ============================================================
  // Outputs, each straight from a flip-flop
  assign sdo_out            = l_r.sdo;
  assign alarm_pin_out      = m_r.pin_val;
  assign alarm_pin_oe_n_out = m_r.pin_oe_n;
endmodule

// ---- ars_top_asserts.sv ----
// Purpose: Port-level checks for the alarm status readout block.
// Assumes: Alarm inputs stay put for several mclk cycles at a time.
// Notes:   Frame bit counter is helper logic in the sclk domain.
module ars_chk (
  input wire logic                mclk_in,
  input wire logic                rst_in,
  input wire logic                sclk_in,
  input wire logic                sync_n_in,
  input wire logic                sdo_out,
  input wire ars_pkg::ars_alarm_t alarm_live_n_in,
  input wire logic [2:0]          alarm_pin_out,
  input wire logic [2:0]          alarm_pin_oe_n_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Frame position
  logic [4:0] bit_cnt_r;
  // Cleared on frame end since sclk stands still between frames
  always_ff @(posedge sclk_in or posedge sync_n_in) begin
    if (sync_n_in) bit_cnt_r <= 5'h00;
    else if (bit_cnt_r != 5'h1f) bit_cnt_r <= bit_cnt_r + 5'h01;
  end

  // ==========================================
  // Checks
  property p_pin_low;
    @(posedge mclk_in) disable iff (rst_in) alarm_pin_out == 3'h0;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin high");
  property p_rel;
    @(posedge mclk_in) disable iff (rst_in)
      $fell(rst_in) |-> alarm_pin_oe_n_out == 3'h7;
  endproperty
  a_rel: assert property (p_rel) else $error("pins held at reset");
  property p_temp_set;
    @(posedge mclk_in) disable iff (rst_in)
      (!alarm_live_n_in.temp) [*8] |-> !alarm_pin_oe_n_out[0];
  endproperty
  a_temp_set: assert property (p_temp_set) else $error("temp pin");
  property p_clamp_set;
    @(posedge mclk_in) disable iff (rst_in)
      (!alarm_live_n_in.clamp) [*8] |-> !alarm_pin_oe_n_out[1];
  endproperty
  a_clamp_set: assert property (p_clamp_set) else $error("clamp pin");
  property p_open_set;
    @(posedge mclk_in) disable iff (rst_in)
      (!alarm_live_n_in.open_sense) [*8] |-> !alarm_pin_oe_n_out[2];
  endproperty
  a_open_set: assert property (p_open_set) else $error("open pin");
  property p_gnd_set;
    @(posedge mclk_in) disable iff (rst_in)
      (!alarm_live_n_in.gnd_kelvin) [*8] |-> !alarm_pin_oe_n_out[2];
  endproperty
  a_gnd_set: assert property (p_gnd_set) else $error("kelvin pin");
  property p_quiet;
    @(posedge mclk_in) disable iff (rst_in)
      alarm_live_n_in.temp [*8] |-> ##1 !$fell(alarm_pin_oe_n_out[0]);
  endproperty
  a_quiet: assert property (p_quiet) else $error("temp pin false set");
  property p_tail;
    @(posedge sclk_in) disable iff (rst_in) bit_cnt_r >= 5'h11 |-> !sdo_out;
  endproperty
  a_tail: assert property (p_tail) else $error("sdo tail not zero");
endmodule

bind ars_top ars_chk u_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .sclk_in(sclk_in),
  .sync_n_in(sync_n_in), .sdo_out(sdo_out),
  .alarm_live_n_in(alarm_live_n_in), .alarm_pin_out(alarm_pin_out),
  .alarm_pin_oe_n_out(alarm_pin_oe_n_out));

// ---- ars_host.sv ----
// Purpose: Serial host that frames reads and writes to the block.
// Assumes: sclk at 125 ns; sdi launched on fall, sampled on rise; sdo read on fall.
// Notes:   sclk only runs inside frames, except for reset pulses.
module ars_host (
  output logic       sclk_out,
  output logic       sync_n_out,
  output logic       sdi_out,
  input  wire logic  sdo_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_out = 1'b0;
    sync_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // Link reset only reaches the sclk side while sclk toggles
  task automatic pulses(input int n);
    repeat (n) begin
      #62.5 sclk_out = 1'b1;
      #62.5 sclk_out = 1'b0;
    end
  endtask
  // One 24-bit frame, MSB first; returns the word shifted out
  task automatic xfer(input logic [23:0] w, output logic [15:0] r);
    logic [23:0] got;
    sync_n_out = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi_out = w[i];
      #62.5 sclk_out = 1'b1;
      #62.5 sclk_out = 1'b0;
      got[i] = sdo_in;
    end
    sync_n_out = 1'b1;
    sdi_out = ~sdi_out;
    r = got[23:8];
    #125;
  endtask
endmodule

// ---- tb.sv ----
// Purpose: Self-checking bench for the alarm status readout block.
// Assumes: Alarm inputs change only between frames.
// Notes:   Each frame returns the word captured by the previous read of 0x43 or 0x44.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, sclk, sync_n, sdi, sdo, cl, ch;
  logic [2:0] pin, oe;
  logic [15:0] exp_rb, got, cap, exp_oe;
  logic [23:0] f;
  ars_pkg::ars_alarm_t live, stk;
  int bad_count, compares, op;
  int tab[5] = '{0, 0, 2, 1, 3};

  ars_top dut (.mclk_in(mclk), .rst_in(rst), .sclk_in(sclk),
    .sync_n_in(sync_n), .sdi_in(sdi), .sdo_out(sdo),
    .alarm_live_n_in(live), .cmp_low_in(cl), .cmp_high_in(ch),
    .alarm_pin_out(pin), .alarm_pin_oe_n_out(oe));
  ars_host host (.sclk_out(sclk), .sync_n_out(sync_n), .sdi_out(sdi),
    .sdo_in(sdo));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ==========================================
  // Expectation and reporting
  function automatic logic [15:0] word(input ars_pkg::ars_alarm_t s, l,
                                       input logic a, b);
    logic [15:0] w;
    w = 16'h0000;
    for (int i = 0; i < 5; i++) begin
      w[15-2*i] = s[4-i];
      w[14-2*i] = l[4-i];
    end
    w[5] = a;
    w[4] = b;
    return w;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #300us;
    bad_count++;
    tally_and_finish();
  end

  // ==========================================
  // Main sequence
  initial begin
    rst = 1'b1;
    live = 5'h1f;
    cl = 1'b0;
    ch = 1'b0;
    stk = 5'h1f;
    exp_rb = 16'h0000;
    bad_count = 0;
    compares = 0;
    void'($urandom(99));
    host.pulses(4);
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    host.pulses(4);
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      live <= (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom | $urandom);
      cl <= (i == 0) ? 1'b1 : 1'($urandom);
      ch <= (i == 0) ? 1'b1 : 1'($urandom);
      op = (i < 5) ? tab[i] : int'($urandom % 4);
      repeat (10) @(posedge mclk);
      stk = stk & live;
      cap = word(stk, live, cl, ch);
      exp_oe = {13'h0000, stk.open_sense & stk.gnd_kelvin,
                stk.clamp, stk.temp};
      chk("oe", exp_oe, {13'h0000, oe});
      chk("pin", 16'h0000, {13'h0000, pin});
      case (op)
        0: f = {1'b1, 7'h43, 16'h0000};
        1: f = {1'b1, 7'h44, 16'h0000};
        2: f = {1'b0, 7'h44, 16'hffff};
        default: f = {1'b1, 7'h45, 16'h0000};
      endcase
      host.xfer(f, got);
      chk("rb", exp_rb, got);
      if (op < 2) exp_rb = cap;
      if (op == 1) stk = live;
    end
    host.xfer(24'h000000, got);
    chk("rb", exp_rb, got);
    tally_and_finish();
  end
endmodule
